// ### rtl/stall_pkg.sv
// Shared constants, types and helpers of the stall prevention supervisor
package stall_pkg;
    // Timebase: one millisecond enable pulse from the control clock
    localparam int CLK_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int TICK_CYCLES = MS_NS / CLK_NS;
    localparam int TICK_MS = 1;
    // Overload flag stays up strictly longer than this
    localparam int OL_HOLD_MS = 100;
    localparam logic [15:0] OL_HOLD_TICKS = 16'(OL_HOLD_MS / TICK_MS + 1);
    // Low-frequency stall time before the stop fault
    localparam int STALL_STOP_MS = 3000;
    localparam logic [15:0] STALL_STOP_TICKS = 16'(STALL_STOP_MS / TICK_MS);
    // One unit of the flag delay setting is 0.1 s
    localparam int DELAY_STEP_MS = 100;
    localparam logic [15:0] DELAY_STEP_TICKS = 16'(DELAY_STEP_MS / TICK_MS);
    localparam logic [15:0] DELAY_MAX = 16'h00FA;
    // Settings are in 0.1 % and 0.01 Hz units; 9999 means off
    localparam logic [15:0] SETTING_OFF = 16'h270F;
    localparam logic [15:0] LEVEL_DEFAULT = 16'h05DC;
    localparam logic [15:0] COMP_UNITY = 16'h03E8;
    localparam logic [15:0] FREQ_TOP = 16'h9C40;
    localparam logic [15:0] FREQ_STALL_FLOOR = 16'h0064;
    localparam logic [15:0] FREQ_TORQUE_MIN = 16'h01F4;
    localparam logic [15:0] REDUCE_START_DEFAULT = 16'h1388;
    // Terminal function codes
    localparam logic [7:0] FN_SECOND_SELECT = 8'h03;
    localparam logic [7:0] FN_OL_POS = 8'h03;
    localparam logic [7:0] FN_OL_NEG = 8'h67;
    localparam int N_IN = 7;
    localparam int N_OUT = 3;
    localparam int REVERSE_SHIFT = 3;
    localparam logic [16:0] TICK_RESET = 17'h00000;

    typedef enum logic [1:0] {RAMP_ACCEL, RAMP_CONST, RAMP_DECEL} ramp_t;

    typedef struct packed {
        logic [15:0] stall_current_level;
        logic [15:0] second_stall_current;
        logic [15:0] high_speed_comp_factor;
        logic [15:0] reduction_start_freq;
        logic [15:0] overload_flag_delay;
        logic [15:0] max_freq;
        logic limit_quantity_select;
    } stall_cfg_t;

    typedef struct packed {
        logic [15:0] output_current;
        logic [15:0] torque_current;
        logic [15:0] output_freq;
        ramp_t ramp;
        logic regen;
        logic regen_avoid_active;
        logic overvoltage_stall_event;
        logic fast_limit_active;
    } drive_stat_t;

    typedef struct packed {
        logic ramp_hold;
        logic ramp_reverse;
        logic freq_trim;
        logic freq_raise;
    } stall_cmd_t;

    // Level seen on an output terminal for a given function code
    function automatic logic term_drive(logic [7:0] code, logic flag);
        if (code == FN_OL_POS) begin
            return flag;
        end
        if (code == FN_OL_NEG) begin
            return ~flag;
        end
        return 1'b0;
    endfunction : term_drive
endpackage : stall_pkg

// ### rtl/stall_level_calc.sv
// High-frequency reduction of the stall level, registered
`timescale 1ns/1ps
module stall_level_calc (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [15:0] base_level,
    input wire logic [15:0] comp_factor,
    input wire logic [15:0] start_freq,
    input wire logic [15:0] out_freq,
    output logic [15:0] level_q
);
    logic [15:0] level_d;
    logic signed [47:0] ls, cs, sl, a, b, num, den, lvl;

    // Wide signed math; the divides settle within one control cycle
    always_comb begin
        ls = signed'(48'(base_level));
        cs = signed'(48'(comp_factor));
        sl = ls * signed'(48'(start_freq));
        a = (out_freq == 16'h0000) ? ls : sl / signed'(48'(out_freq));
        b = sl / signed'(48'(stall_pkg::FREQ_TOP));
        den = (ls - b) * signed'(48'(stall_pkg::COMP_UNITY));
        num = b * (ls - a) * (cs - signed'(48'(stall_pkg::COMP_UNITY)));
        lvl = ls;
        if (comp_factor != stall_pkg::SETTING_OFF && out_freq > start_freq
            && den != 48'sh0) begin
            lvl = a + num / den;
        end
        if (lvl < 48'sh0) begin
            level_d = 16'h0000;
        end else if (lvl > 48'sh00000000FFFF) begin
            level_d = 16'hFFFF;
        end else begin
            level_d = lvl[15:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            level_q <= 16'h0000;
        end else begin
            level_q <= level_d;
        end
    end
endmodule : stall_level_calc

// ### rtl/ol_flag_timer.sv
// Overload flag with start delay and minimum on time
`timescale 1ns/1ps
module ol_flag_timer (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic trigger,
    input wire logic [15:0] delay,
    output logic flag_q
);
    typedef enum logic [1:0] {OL_IDLE, OL_WAIT, OL_ON} ol_state_t;
    ol_state_t state_q, state_d;
    logic [15:0] cnt_q, cnt_d, wait_ticks;
    logic flag_d, off;

    // Delay in ticks; settings above 25 s are clipped
    always_comb begin
        off = (delay == stall_pkg::SETTING_OFF);
        wait_ticks = 16'((delay > stall_pkg::DELAY_MAX ? stall_pkg::DELAY_MAX : delay)
            * stall_pkg::DELAY_STEP_TICKS);
    end

    // Flag sequencing: wait, assert, hold, release
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        flag_d = flag_q;
        unique case (state_q)
            OL_IDLE: if (trigger && !off) begin
                cnt_d = 16'h0000;
                state_d = (delay == 16'h0000) ? OL_ON : OL_WAIT;
                flag_d = (delay == 16'h0000);
            end
            OL_WAIT: if (!trigger || off) begin
                state_d = OL_IDLE;
            end else if (cnt_q >= wait_ticks) begin
                state_d = OL_ON;
                flag_d = 1'b1;
                cnt_d = 16'h0000;
            end else if (tick) begin
                cnt_d = cnt_q + 16'h0001;
            end
            OL_ON: if (cnt_q < stall_pkg::OL_HOLD_TICKS) begin
                if (tick) begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end else if (!trigger || off) begin
                state_d = OL_IDLE;
                flag_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= OL_IDLE;
            cnt_q <= 16'h0000;
            flag_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            flag_q <= flag_d;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    AST_OL_HOLD: assert property (state_q == OL_ON && cnt_q < stall_pkg::OL_HOLD_TICKS
        |=> flag_q) else $error("overload flag dropped before hold time");
    AST_OL_NOW: assert property (state_q == OL_IDLE && trigger && delay == 16'h0000
        |=> flag_q) else $error("zero delay did not raise flag at once");
    AST_OL_OFF: assert property (off && !flag_q |=> !flag_q)
        else $error("flag raised while suppressed");
endmodule : ol_flag_timer

// ### rtl/motor_stall_prevention_control.sv
// Stall prevention supervisor: level select, compare, ramp commands, flag, fault
`timescale 1ns/1ps

// Summary of operation
// - Level is percent of rated output current
// - Hold or reverse ramps, trim at constant speed
// - Overload flag on over level, held over 100ms
// - Flag drops when current falls to level
// - Delay: 0 now, 0.1-25s delayed, 9999 never
// - Regen avoidance and overvoltage stall also flag
// - Terminal shows flag for code 3 or 103
// - Stuck at 1Hz for 3s raises stop fault
// - Torque mode compares torque current instead
// - Regen torque limit raises frequency to maximum
// - No torque limit decelerating at 5Hz or less
// - Level reduced above reduction start frequency
// - Reduced level follows the compensation formula
// - Factor 9999 keeps base level to 400Hz
// - Second-function input selects second stall current
// - Second input comes from code 3 terminal
// - Second input enables all second-set functions
// - Base level 0 disables stall prevention
// - Second current 9999 keeps base level
// - Fast current limit alone gives no flag
module motor_stall_prevention_control #(
    parameter int TICK_CYCLES = stall_pkg::TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire stall_pkg::stall_cfg_t cfg,
    input wire stall_pkg::drive_stat_t stat,
    input wire logic [stall_pkg::N_IN-1:0] term_in_pin,
    input wire logic [stall_pkg::N_IN-1:0][7:0] input_terminal_assign,
    input wire logic [stall_pkg::N_OUT-1:0][7:0] output_terminal_assign,
    input wire logic fault_clear,
    output stall_pkg::stall_cmd_t cmd_q,
    output logic stall_active_q,
    output logic overload_status_flag,
    output logic [stall_pkg::N_OUT-1:0] term_out_q,
    output logic second_function_select_q,
    output logic stall_stop_fault_q,
    output logic output_shutoff_q,
    output logic [15:0] level_q
);
    localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

    // Timebase state
    logic [16:0] tick_cnt_q, tick_cnt_d;
    logic tick_q, tick_d;

    // Pin synchroniser
    logic [stall_pkg::N_IN-1:0] pin_meta_q, pin_sync_q;
    logic second_d;

    // Level selection and comparison
    logic [15:0] base_level, meas;
    logic enabled, torque_mode, torque_blocked, over, big_over;
    logic ol_trigger;

    // Command state
    stall_pkg::stall_cmd_t cmd_d;
    logic stall_active_d;

    // Low-frequency stall fault state
    logic [15:0] stuck_cnt_q, stuck_cnt_d;
    logic fault_d, shutoff_d;

    // Terminal outputs
    logic [stall_pkg::N_OUT-1:0] term_out_d;

    // One millisecond enable: all slow timing counts these pulses
    always_comb begin
        tick_cnt_d = tick_cnt_q + 17'h00001;
        tick_d = 1'b0;
        if (tick_cnt_q >= TICK_LAST) begin
            tick_cnt_d = stall_pkg::TICK_RESET;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_q <= stall_pkg::TICK_RESET;
            tick_q <= 1'b0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
        end
    end

    // Terminal pins are asynchronous, so two flops before the second-function decode
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= term_in_pin;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Second-function input from any terminal assigned code 3
    always_comb begin
        second_d = 1'b0;
        for (int i = 0; i < stall_pkg::N_IN; i++) begin
            if (input_terminal_assign[i] == stall_pkg::FN_SECOND_SELECT
                && pin_sync_q[i]) begin
                second_d = 1'b1;
            end
        end
    end

    // Exported as the drive-wide second-set select, not only for stall
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            second_function_select_q <= 1'b0;
        end else begin
            second_function_select_q <= second_d;
        end
    end

    // Base level: second current only when selected and not 9999
    always_comb begin
        base_level = cfg.stall_current_level;
        if (second_function_select_q
            && cfg.second_stall_current != stall_pkg::SETTING_OFF) begin
            base_level = cfg.second_stall_current;
        end
    end

    // High-speed reduction of the chosen level; 9999 factor keeps it flat
    stall_level_calc u_level (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .base_level(base_level),
        .comp_factor(cfg.high_speed_comp_factor),
        .start_freq(cfg.reduction_start_freq),
        .out_freq(stat.output_freq),
        .level_q(level_q)
    );

    // Compare every cycle; level lags one cycle behind a setting change
    always_comb begin
        torque_mode = cfg.limit_quantity_select;
        meas = torque_mode ? stat.torque_current : stat.output_current;
        enabled = cfg.stall_current_level != 16'h0000
            && base_level != 16'h0000;
        torque_blocked = torque_mode && stat.ramp == stall_pkg::RAMP_DECEL
            && stat.output_freq <= stall_pkg::FREQ_TORQUE_MIN;
        over = enabled && !torque_blocked && !stall_stop_fault_q
            && meas > level_q;
        // One bit wider so a high level cannot wrap the reverse threshold
        big_over = {1'b0, meas} > (17'(level_q) + 17'(level_q >> stall_pkg::REVERSE_SHIFT));
        // Fast-response limit is not a trigger
        ol_trigger = over || stat.regen_avoid_active
            || stat.overvoltage_stall_event;
    end

    // Ramp commands; a large excess reverses instead of holding
    always_comb begin
        cmd_d = '0;
        stall_active_d = over;
        if (over) begin
            if (torque_mode && stat.regen) begin
                // Raising frequency sheds regenerative torque
                cmd_d.freq_raise = stat.output_freq < cfg.max_freq;
            end else begin
                unique case (stat.ramp)
                    stall_pkg::RAMP_ACCEL,
                    stall_pkg::RAMP_DECEL: begin
                        cmd_d.ramp_hold = !big_over;
                        cmd_d.ramp_reverse = big_over;
                    end
                    stall_pkg::RAMP_CONST: cmd_d.freq_trim = 1'b1;
                    default: cmd_d.ramp_hold = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_q <= '0;
            stall_active_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            stall_active_q <= stall_active_d;
        end
    end

    // Overload flag timing lives in its own small sequencer
    ol_flag_timer u_ol (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .tick(tick_q),
        .trigger(ol_trigger),
        .delay(cfg.overload_flag_delay),
        .flag_q(overload_status_flag)
    );

    // Stop fault after a long stall at the floor frequency; set beats clear
    always_comb begin
        stuck_cnt_d = stuck_cnt_q;
        fault_d = stall_stop_fault_q;
        if (!(stall_active_q && stat.output_freq <= stall_pkg::FREQ_STALL_FLOOR)) begin
            stuck_cnt_d = 16'h0000;
        end else if (stuck_cnt_q >= stall_pkg::STALL_STOP_TICKS) begin
            fault_d = 1'b1;
            stuck_cnt_d = 16'h0000;
        end else if (tick_q) begin
            stuck_cnt_d = stuck_cnt_q + 16'h0001;
        end
        if (fault_clear && !(fault_d && !stall_stop_fault_q)) begin
            fault_d = 1'b0;
        end
        shutoff_d = fault_d;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stuck_cnt_q <= 16'h0000;
            stall_stop_fault_q <= 1'b0;
            output_shutoff_q <= 1'b0;
        end else begin
            stuck_cnt_q <= stuck_cnt_d;
            stall_stop_fault_q <= fault_d;
            output_shutoff_q <= shutoff_d;
        end
    end

    // Output terminals follow the flag only for codes 3 and 103
    always_comb begin
        for (int j = 0; j < stall_pkg::N_OUT; j++) begin
            term_out_d[j] = stall_pkg::term_drive(output_terminal_assign[j],
                overload_status_flag);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            term_out_q <= '0;
        end else begin
            term_out_q <= term_out_d;
        end
    end

    // Checks; the pin match below is read by checks only
    logic pin_hit;
    always_comb begin
        pin_hit = 1'b0;
        for (int k = 0; k < stall_pkg::N_IN; k++) begin
            if (input_terminal_assign[k] == stall_pkg::FN_SECOND_SELECT) begin
                pin_hit = pin_hit | term_in_pin[k];
            end
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_pin_held;
        pin_hit [*3];
    endsequence

    sequence s_floor_stall;
        stall_active_q && stat.output_freq <= stall_pkg::FREQ_STALL_FLOOR;
    endsequence

    AST_SECOND_SYNC: assert property (s_pin_held |=> second_function_select_q)
        else $error("second-function input not taken from pin");
    AST_SECOND_LEVEL: assert property (second_function_select_q
        && cfg.second_stall_current == stall_pkg::SETTING_OFF
        |-> base_level == cfg.stall_current_level)
        else $error("9999 second current did not keep base level");
    AST_DISABLED: assert property (cfg.stall_current_level == 16'h0000
        |=> cmd_q == '0 && !stall_active_q)
        else $error("stall action while disabled");
    AST_TORQUE_LOW: assert property (torque_mode && stat.ramp == stall_pkg::RAMP_DECEL
        && stat.output_freq <= stall_pkg::FREQ_TORQUE_MIN |=> !stall_active_q)
        else $error("torque limit acted at low decel frequency");
    AST_RAISE_BOUND: assert property (cmd_q.freq_raise
        |-> $past(stat.output_freq) < $past(cfg.max_freq) && $past(stat.regen))
        else $error("frequency raised beyond maximum");
    AST_CONST_TRIM: assert property (over && !torque_mode
        && stat.ramp == stall_pkg::RAMP_CONST |=> cmd_q.freq_trim && !cmd_q.ramp_hold)
        else $error("constant speed stall did not trim frequency");
    AST_FAULT_TIME: assert property ($rose(stall_stop_fault_q)
        |-> $past(stuck_cnt_q) >= stall_pkg::STALL_STOP_TICKS)
        else $error("stop fault raised before stall time");
    AST_FAULT_SET: assert property (s_floor_stall ##0
        stuck_cnt_q >= stall_pkg::STALL_STOP_TICKS |=> stall_stop_fault_q ##1 output_shutoff_q)
        else $error("stop fault or shutoff missing after stall time");
    AST_NO_FAST_OL: assert property (!ol_trigger && !overload_status_flag
        |=> !overload_status_flag)
        else $error("flag raised without a stall cause");
    AST_TERM_POL: assert property (output_terminal_assign[1] == stall_pkg::FN_OL_NEG
        && $stable(output_terminal_assign[1]) |=> term_out_q[1] == !$past(overload_status_flag))
        else $error("negative logic terminal mismatch");
endmodule : motor_stall_prevention_control

// ### verification/motor_model.sv
// Behavioural motor and output stage that returns the measured drive status
`timescale 1ns/1ps
module motor_model (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire stall_pkg::drive_stat_t demand,
    output stall_pkg::drive_stat_t stat
);
    // Measurement lags the demand by one control cycle, as a sensing path would
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stat <= '0;
        end else begin
            stat <= demand;
        end
    end
endmodule : motor_model

// ### verification/testbench.sv
// Self-checking bench of the stall prevention supervisor
`timescale 1ns/1ps
module testbench;
    localparam int TICKS = 10;
    typedef struct {int id; logic [15:0] exp;} note_t;
    logic sys_clk;
    logic rst_b;
    stall_pkg::stall_cfg_t cfg;
    stall_pkg::drive_stat_t dem;
    stall_pkg::drive_stat_t stat;
    logic [stall_pkg::N_IN-1:0] pins;
    logic [stall_pkg::N_IN-1:0][7:0] in_asg;
    logic [stall_pkg::N_OUT-1:0][7:0] out_asg;
    logic fault_clear;
    stall_pkg::stall_cmd_t cmd_q;
    logic stall_active_q;
    logic flag;
    logic second_q;
    logic fault_q;
    logic shutoff_q;
    logic [2:0] term_q;
    logic [15:0] level_q;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] rnd = 32'hD93E;
    note_t notes[$];
    note_t cur;

    motor_stall_prevention_control #(.TICK_CYCLES(TICKS)) u_motor_stall_prevention_control (
        .sys_clk(sys_clk), .rst_b(rst_b), .cfg(cfg), .stat(stat), .term_in_pin(pins),
        .input_terminal_assign(in_asg), .output_terminal_assign(out_asg),
        .fault_clear(fault_clear), .cmd_q(cmd_q), .stall_active_q(stall_active_q),
        .overload_status_flag(flag), .term_out_q(term_q), .second_function_select_q(second_q),
        .stall_stop_fault_q(fault_q), .output_shutoff_q(shutoff_q), .level_q(level_q)
    );
    motor_model u_motor_model (.sys_clk(sys_clk), .rst_b(rst_b), .demand(dem), .stat(stat));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    // Ids: 0 cmd, 1 stall active, 2 flag, 3 terminals, 4 second, 5 fault, 6 shutoff, 7 level
    task automatic note(input int id, input logic [15:0] exp);
        notes.push_back('{id, exp});
    endtask : note

    task automatic drive(input logic [15:0] c, input logic [15:0] f, input stall_pkg::ramp_t r);
        @(posedge sys_clk);
        dem.output_current <= c;
        dem.output_freq <= f;
        dem.ramp <= r;
    endtask : drive

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %b, seen %b", nm, e, g);
        end
    endtask : cmp_bit

    task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : cmp_word

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    // Checks are taken at the falling edge so registered outputs have settled
    always @(negedge sys_clk) begin
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            case (cur.id)
                0: cmp_word("cmd_q", cur.exp, {12'h000, cmd_q});
                1: cmp_bit("stall_active_q", cur.exp[0], stall_active_q);
                2: cmp_bit("overload_status_flag", cur.exp[0], flag);
                3: cmp_word("term_out_q", cur.exp, {13'h0000, term_q});
                4: cmp_bit("second_function_select_q", cur.exp[0], second_q);
                5: cmp_bit("stall_stop_fault_q", cur.exp[0], fault_q);
                6: cmp_bit("output_shutoff_q", cur.exp[0], shutoff_q);
                default: cmp_word("level_q", cur.exp, level_q);
            endcase
        end
    end

    // Hang guard: the whole sequence needs about 37000 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 45000) begin
            fails++;
            summarize();
        end
    end

    initial begin
        rst_b = 1'b0;
        fault_clear = 1'b0;
        pins = '0;
        in_asg = '0;
        out_asg = {8'h00, 8'h67, 8'h03};
        dem = '0;
        dem.output_freq = 16'h0BB8;
        cfg.stall_current_level = stall_pkg::LEVEL_DEFAULT;
        cfg.second_stall_current = 16'h03E8;
        cfg.high_speed_comp_factor = stall_pkg::SETTING_OFF;
        cfg.reduction_start_freq = 16'h1388;
        cfg.overload_flag_delay = 16'h0000;
        cfg.max_freq = 16'h9C40;
        cfg.limit_quantity_select = 1'b0;
        cyc(8);
        note(3, 16'h0000);
        cyc(2);
        rst_b <= 1'b1;
        cyc(3);
        note(7, 16'h05DC);
        note(3, 16'h0002);
        // Small random excess over the level: hold, trim, hold per ramp state
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            drive(16'h05DD + 16'(rnd % 180), 16'h0BB8, stall_pkg::ramp_t'(k));
            cyc(4);
            note(0, (k == 1) ? 16'h0002 : 16'h0008);
            note(1, 16'h0001);
        end
        note(2, 16'h0001);
        note(3, 16'h0001);
        drive(16'h0708, 16'h0BB8, stall_pkg::RAMP_ACCEL);
        cyc(4);
        note(0, 16'h0004);
        // Current equal to the level ends stalling, flag keeps its minimum on time
        drive(16'h05DC, 16'h0BB8, stall_pkg::RAMP_ACCEL);
        cyc(4);
        note(1, 16'h0000);
        cyc(900);
        note(2, 16'h0001);
        cyc(200);
        note(2, 16'h0000);
        note(3, 16'h0002);
        // Delayed flag, then flag suppressed
        cfg.overload_flag_delay <= 16'h0001;
        drive(16'h0640, 16'h0BB8, stall_pkg::RAMP_CONST);
        cyc(900);
        note(2, 16'h0000);
        cyc(150);
        note(2, 16'h0001);
        drive(16'h03E8, 16'h0BB8, stall_pkg::RAMP_CONST);
        cyc(1100);
        note(2, 16'h0000);
        cfg.overload_flag_delay <= stall_pkg::SETTING_OFF;
        drive(16'h0640, 16'h0BB8, stall_pkg::RAMP_CONST);
        cyc(1200);
        note(2, 16'h0000);
        cfg.overload_flag_delay <= 16'h0000;
        drive(16'h03E8, 16'h0BB8, stall_pkg::RAMP_CONST);
        // Regeneration avoidance and overvoltage stall raise the flag too
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            dem.regen_avoid_active <= (k == 0);
            dem.overvoltage_stall_event <= (k == 1);
            cyc(4);
            note(2, 16'h0001);
            dem.regen_avoid_active <= 1'b0;
            dem.overvoltage_stall_event <= 1'b0;
            cyc(1100);
            note(2, 16'h0000);
        end
        dem.fast_limit_active <= 1'b1;
        cyc(20);
        note(2, 16'h0000);
        dem.fast_limit_active <= 1'b0;
        cfg.stall_current_level <= 16'h0000;
        drive(16'h0640, 16'h0BB8, stall_pkg::RAMP_ACCEL);
        cyc(4);
        note(1, 16'h0000);
        note(0, 16'h0000);
        cfg.stall_current_level <= stall_pkg::LEVEL_DEFAULT;
        // Torque mode: low output current, torque current over the level
        cfg.limit_quantity_select <= 1'b1;
        dem.torque_current <= 16'h0640;
        drive(16'h03E8, 16'h0BB8, stall_pkg::RAMP_CONST);
        cyc(4);
        note(0, 16'h0002);
        dem.regen <= 1'b1;
        cyc(4);
        note(0, 16'h0001);
        dem.regen <= 1'b0;
        drive(16'h03E8, 16'h01F4, stall_pkg::RAMP_DECEL);
        cyc(4);
        note(1, 16'h0000);
        drive(16'h03E8, 16'h0258, stall_pkg::RAMP_DECEL);
        cyc(4);
        note(1, 16'h0001);
        dem.torque_current <= 16'h0000;
        cfg.limit_quantity_select <= 1'b0;
        // Level reduction: 150 % at 100 Hz from 50 Hz with unity factor gives 75 %
        cfg.high_speed_comp_factor <= stall_pkg::COMP_UNITY;
        drive(16'h03E8, 16'h2710, stall_pkg::RAMP_CONST);
        cyc(4);
        note(7, 16'h02EE);
        // Half factor: 750 + 187 * 750 / 1313 * -0.5, truncated toward zero
        cfg.high_speed_comp_factor <= 16'h01F4;
        cyc(4);
        note(7, 16'h02B9);
        drive(16'h03E8, 16'h0FA0, stall_pkg::RAMP_CONST);
        cyc(4);
        note(7, 16'h05DC);
        cfg.high_speed_comp_factor <= stall_pkg::SETTING_OFF;
        drive(16'h03E8, 16'h9C40, stall_pkg::RAMP_CONST);
        cyc(4);
        note(7, 16'h05DC);
        // Second function from the code 3 terminal only
        in_asg[4] <= 8'h03;
        pins[1] <= 1'b1;
        cyc(6);
        note(4, 16'h0000);
        pins[4] <= 1'b1;
        drive(16'h04B0, 16'h0BB8, stall_pkg::RAMP_ACCEL);
        cyc(8);
        note(4, 16'h0001);
        note(7, 16'h03E8);
        note(1, 16'h0001);
        cfg.second_stall_current <= stall_pkg::SETTING_OFF;
        cyc(4);
        note(7, 16'h05DC);
        note(1, 16'h0000);
        pins <= '0;
        cfg.second_stall_current <= 16'h03E8;
        // Stalled at the 1 Hz floor long enough to trip
        drive(16'h0640, 16'h0064, stall_pkg::RAMP_ACCEL);
        cyc(29000);
        note(5, 16'h0000);
        cyc(1100);
        note(5, 16'h0001);
        note(6, 16'h0001);
        note(0, 16'h0000);
        drive(16'h03E8, 16'h0BB8, stall_pkg::RAMP_ACCEL);
        fault_clear <= 1'b1;
        @(posedge sys_clk);
        fault_clear <= 1'b0;
        cyc(4);
        note(5, 16'h0000);
        note(6, 16'h0000);
        cyc(2);
        summarize();
    end
endmodule : testbench
